// File: rtl/uart_rx_baud_pkg.sv
package uart_rx_baud_pkg;
	// apb address map, byte addresses of aligned words
	localparam int addr_width = 8;
	localparam logic [7:0] off_receive_status_control = 8'h00;
	localparam logic [7:0] off_baud_control = 8'h04;
	localparam logic [7:0] off_divisor_low_byte = 8'h08;
	localparam logic [7:0] off_divisor_high_byte = 8'h0c;
	localparam logic [7:0] off_receive_data_register = 8'h10;
	localparam logic [7:0] off_mode_config = 8'h14;

	// receive_status_control fields
	localparam int bit_port_enable = 7;
	localparam int bit_ninth_bit_receive_select = 6;
	localparam int bit_single_receive_enable = 5;
	localparam int bit_continuous_receive_enable = 4;
	localparam int bit_address_detect_enable = 3;
	localparam int bit_framing_error_flag = 2;
	localparam int bit_overrun_error_flag = 1;
	localparam int bit_received_ninth_bit = 0;

	// baud_control fields
	localparam int bit_autobaud_rollover_flag = 7;
	localparam int bit_receive_idle_status = 6;
	localparam int bit_sync_clock_polarity = 4;
	localparam int bit_wide_divisor_select = 3;
	localparam int bit_wakeup_enable = 1;
	localparam int bit_autobaud_enable = 0;

	// mode_config fields
	localparam int bit_sync_mode = 0;
	localparam int bit_clock_master = 1;
	localparam int bit_high_speed_select = 2;

	// reset values
	localparam logic [7:0] reset_byte = 8'h00;
	localparam logic [15:0] reset_divisor = 16'h0000;

	// generator ticks per bit
	localparam logic [6:0] div_low_speed = 7'h40;
	localparam logic [6:0] div_high_speed = 7'h10;
	localparam logic [6:0] div_fast = 7'h04;

	// data bits per character
	localparam logic [3:0] bits_narrow = 4'h8;
	localparam logic [3:0] bits_wide = 4'h9;

	// falling edges of the sync value after the first one, minus one
	localparam logic [2:0] autobaud_last_fall = 3'h3;
	localparam logic [15:0] meas_max_narrow = 16'h00ff;
	localparam logic [15:0] meas_max_wide = 16'hffff;

	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_start = 2'b01,
		st_data = 2'b11,
		st_stop = 2'b10
	} rx_state_type;
endpackage

// File: rtl/uart_receive_and_baud_control.sv
// Overview of operation
// RQ1: port enable takes pins, else inactive
// RQ2: ninth bit select picks 9 or 8 bits
// RQ3: sync master single receive, self clearing
// RQ4: async continuous enable switches receiver
// RQ5: sync continuous receive overrides single receive
// RQ6: address detect loads only ninth-bit-set characters
// RQ7: framing flag updated per loaded character
// RQ8: overrun on loss, cleared by continuous clear
// RQ9: ninth received bit in status bit 0
// RQ10: autobaud rollover flag, software clears only
// RQ11: idle status high when not receiving
// RQ12: sync clock idle level follows polarity
// RQ13: 8-bit generator default, 16-bit when selected
// RQ14: wake-up falling edge interrupt, rising clears
// RQ15: autobaud measures sync value, self clearing
// RQ16: divisor pair sets free-running timer period
// RQ17: async speed selects matter, sync ignores high-speed
// RQ18: generated rate only as clock master
// RQ19: divisor write resets the timer
// RQ20: timer counts system clock, reload on change
// RQ21: rate is clock over 64, 16, 4 times n+1
// RQ22: three samples, majority vote
// RQ23: high-speed select picks divider in async
// RQ24: no buffer loads while overrun set
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
module uart_receive_and_baud_control (
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [uart_rx_baud_pkg::addr_width-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// pins
	input wire logic receive_pin,
	input wire logic serial_clock_in,
	output logic serial_clock_out,
	output logic serial_clock_oe,
	output logic port_active,
	// events
	output logic receive_data_ready,
	output logic wakeup_interrupt
);
	import uart_rx_baud_pkg::*;

	function automatic logic hit(input logic [addr_width-1:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	function automatic logic [6:0] bit_divide(input logic syn, input logic wide, input logic fast);
		if (syn) begin
			bit_divide = div_fast;
		end else if (wide) begin
			bit_divide = fast ? div_fast : div_high_speed;
		end else begin
			bit_divide = fast ? div_high_speed : div_low_speed;
		end
	endfunction

	// control and status
	logic port_enable, ninth_bit_receive_select, single_receive_enable;
	logic continuous_receive_enable, address_detect_enable;
	logic framing_error_flag, overrun_error_flag, received_ninth_bit;
	logic autobaud_rollover_flag, sync_clock_polarity, wide_divisor_select;
	logic wakeup_enable, autobaud_enable, sync_mode, clock_master, high_speed_select;
	logic [7:0] divisor_low_byte, divisor_high_byte, receive_data_register;
	logic receive_full;

	// pin synchronisers
	logic rx_meta, rx_sync, rx_prev, ck_meta, ck_sync, ck_prev;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_meta <= 1'b1;
			rx_sync <= 1'b1;
			rx_prev <= 1'b1;
			ck_meta <= 1'b0;
			ck_sync <= 1'b0;
			ck_prev <= 1'b0;
		end else begin
			rx_meta <= receive_pin;
			rx_sync <= rx_meta;
			rx_prev <= rx_sync;
			ck_meta <= serial_clock_in;
			ck_sync <= ck_meta;
			ck_prev <= ck_sync;
		end
	end
	wire rx_fall = rx_prev & ~rx_sync;
	wire rx_rise = ~rx_prev & rx_sync;

	// bus decode
	wire wr = psel & penable & pwrite;
	wire rd = psel & penable & ~pwrite;
	wire sel_rsc = hit(paddr, off_receive_status_control);
	wire sel_baud = hit(paddr, off_baud_control);
	wire sel_lo = hit(paddr, off_divisor_low_byte);
	wire sel_hi = hit(paddr, off_divisor_high_byte);
	wire sel_data = hit(paddr, off_receive_data_register);
	wire sel_mode = hit(paddr, off_mode_config);
	wire mapped = sel_rsc | sel_baud | sel_lo | sel_hi | sel_data | sel_mode;
	wire wr_rsc = wr & sel_rsc;
	wire wr_baud = wr & sel_baud;
	wire wr_div = wr & (sel_lo | sel_hi);
	wire rd_data = rd & sel_data;

	// modes
	wire master_mode = sync_mode & clock_master;
	wire slave_mode = sync_mode & ~clock_master;
	wire async_run = port_enable & ~sync_mode & continuous_receive_enable
		& ~wakeup_enable & ~autobaud_enable; // RQ4
	wire sync_run = port_enable & sync_mode
		& (continuous_receive_enable | (master_mode & single_receive_enable)); // RQ3 RQ5
	wire autobaud_run = port_enable & ~sync_mode & autobaud_enable;

	// baud generator
	logic [15:0] brg_count;
	wire [15:0] divisor = wide_divisor_select ? {divisor_high_byte, divisor_low_byte}
		: {8'h00, divisor_low_byte}; // RQ13 RQ16
	wire tick = (brg_count == 16'h0000);
	wire [6:0] bit_div = bit_divide(sync_mode, wide_divisor_select, high_speed_select); // RQ17 RQ21 RQ23
	wire [5:0] ph_last = 6'(bit_div - 7'h01);
	wire [5:0] ph_mid = 6'(bit_div >> 1);
	logic ab_done;
	logic [15:0] ab_value;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			brg_count <= reset_divisor;
		end else if (wr_div || ab_done || tick) begin
			brg_count <= divisor; // RQ19 RQ20
		end else begin
			brg_count <= brg_count - 16'h0001;
		end
	end

	// receive state machine
	rx_state_type state, next_state;
	logic [5:0] ph, next_ph;
	logic [3:0] count, next_count;
	logic [8:0] shift, next_shift;
	logic s0, s1;
	logic char_done, frame_bad;
	wire [3:0] char_bits = ninth_bit_receive_select ? bits_wide : bits_narrow; // RQ2
	wire vote = (s0 & s1) | (s0 & rx_sync) | (s1 & rx_sync); // RQ22
	wire async_strobe = tick & (ph == 6'(ph_mid + 6'h01));
	wire slave_edge = (ck_sync != ck_prev) & (ck_prev == sync_clock_polarity);
	wire sync_strobe = master_mode ? (tick & (ph == ph_last)) : (slave_mode & slave_edge); // RQ18
	wire run_ok = sync_mode ? sync_run : async_run;

	always_comb begin
		next_state = state;
		next_ph = ph;
		next_count = count;
		next_shift = shift;
		char_done = 1'b0;
		frame_bad = 1'b0;
		if (tick && state != st_idle) begin
			next_ph = (ph == ph_last) ? 6'h00 : 6'(ph + 6'h01);
		end
		unique case (state)
			st_idle: begin
				if (async_run && rx_fall) begin
					next_state = st_start;
					next_ph = 6'h00;
				end else if (sync_run) begin
					next_state = st_data;
					next_ph = 6'h00;
					next_count = 4'h0;
				end
			end
			st_start: begin
				if (!async_run) begin
					next_state = st_idle;
				end else if (async_strobe) begin
					next_state = vote ? st_idle : st_data;
					next_count = 4'h0;
				end
			end
			st_data: begin
				if (!run_ok) begin
					next_state = st_idle;
				end else if (sync_mode ? sync_strobe : async_strobe) begin
					next_shift = {sync_mode ? rx_sync : vote, shift[8:1]};
					next_count = 4'(count + 4'h1);
					if (count == 4'(char_bits - 4'h1)) begin
						next_count = 4'h0;
						if (sync_mode) begin
							char_done = 1'b1;
							next_state = continuous_receive_enable ? st_data : st_idle; // RQ5
						end else begin
							next_state = st_stop;
						end
					end
				end
			end
			st_stop: begin
				if (!async_run) begin
					next_state = st_idle;
				end else if (async_strobe) begin
					char_done = 1'b1;
					frame_bad = ~vote; // RQ7
					next_state = st_idle;
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= st_idle;
			ph <= 6'h00;
			count <= 4'h0;
			shift <= 9'h000;
		end else begin
			state <= next_state;
			ph <= next_ph;
			count <= next_count;
			shift <= next_shift;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s0 <= 1'b1;
			s1 <= 1'b1;
		end else if (tick) begin
			if (ph == 6'(ph_mid - 6'h01)) s0 <= rx_sync;
			if (ph == ph_mid) s1 <= rx_sync;
		end
	end

	// character acceptance
	wire [7:0] char_data = ninth_bit_receive_select ? next_shift[7:0] : next_shift[8:1];
	wire char_ninth = ninth_bit_receive_select & next_shift[8];
	wire addr_skip = ~sync_mode & ninth_bit_receive_select & address_detect_enable
		& ~char_ninth; // RQ6
	wire accept = char_done & ~overrun_error_flag & ~addr_skip; // RQ24
	wire lost = accept & receive_full & ~rd_data;
	wire load = accept & ~lost;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			receive_data_register <= reset_byte;
			received_ninth_bit <= 1'b0;
			framing_error_flag <= 1'b0;
		end else if (load) begin
			receive_data_register <= char_data;
			received_ninth_bit <= char_ninth; // RQ9
			framing_error_flag <= frame_bad; // RQ7
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			receive_full <= 1'b0;
			overrun_error_flag <= 1'b0;
		end else begin
			receive_full <= load | (receive_full & ~rd_data);
			overrun_error_flag <= lost | (overrun_error_flag
				& ~(wr_rsc & ~pwdata[bit_continuous_receive_enable])); // RQ8
		end
	end

	// auto-baud measurement
	logic ab_active;
	logic [2:0] ab_falls;
	logic [9:0] ab_pre;
	logic [15:0] ab_meas;
	wire [9:0] ab_pre_last = 10'({bit_div, 3'b000} - 10'h001);
	wire [15:0] meas_max = wide_divisor_select ? meas_max_wide : meas_max_narrow;
	wire ab_roll = ab_active & (ab_pre == ab_pre_last) & (ab_meas == meas_max);
	assign ab_done = ab_active & autobaud_run & rx_fall & (ab_falls == autobaud_last_fall);
	assign ab_value = (ab_meas == 16'h0000) ? 16'h0000 : 16'(ab_meas - 16'h0001);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ab_active <= 1'b0;
			ab_falls <= 3'h0;
			ab_pre <= 10'h000;
			ab_meas <= 16'h0000;
		end else if (!autobaud_run || ab_done) begin
			ab_active <= 1'b0;
		end else if (!ab_active) begin
			ab_active <= rx_fall; // RQ15
			ab_falls <= 3'h0;
			ab_pre <= 10'h000;
			ab_meas <= 16'h0000;
		end else begin
			ab_pre <= (ab_pre == ab_pre_last) ? 10'h000 : 10'(ab_pre + 10'h001);
			if (ab_pre == ab_pre_last) ab_meas <= 16'(ab_meas + 16'h0001);
			if (rx_fall) ab_falls <= 3'(ab_falls + 3'h1);
		end
	end

	// wake-up monitor
	logic wake_armed;
	wire wake_watch = port_enable & ~sync_mode & wakeup_enable;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_armed <= 1'b0;
			wakeup_interrupt <= 1'b0;
		end else begin
			wakeup_interrupt <= wake_watch & rx_fall; // RQ14
			if (!wake_watch || rx_rise) wake_armed <= 1'b0;
			else if (rx_fall) wake_armed <= 1'b1;
		end
	end
	wire wake_done = wake_watch & wake_armed & rx_rise;

	// software registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{port_enable, ninth_bit_receive_select, single_receive_enable} <= 3'h0;
			{continuous_receive_enable, address_detect_enable} <= 2'h0;
		end else begin
			if (wr_rsc) begin
				port_enable <= pwdata[bit_port_enable];
				ninth_bit_receive_select <= pwdata[bit_ninth_bit_receive_select];
				single_receive_enable <= pwdata[bit_single_receive_enable];
				continuous_receive_enable <= pwdata[bit_continuous_receive_enable];
				address_detect_enable <= pwdata[bit_address_detect_enable];
			end
			if (char_done && master_mode && !continuous_receive_enable) begin
				single_receive_enable <= 1'b0; // RQ3
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{sync_clock_polarity, wide_divisor_select, wakeup_enable} <= 3'h0;
			{autobaud_enable, autobaud_rollover_flag} <= 2'h0;
			{sync_mode, clock_master, high_speed_select} <= 3'h0;
		end else begin
			if (wr_baud) begin
				sync_clock_polarity <= pwdata[bit_sync_clock_polarity];
				wide_divisor_select <= pwdata[bit_wide_divisor_select];
				wakeup_enable <= pwdata[bit_wakeup_enable];
				autobaud_enable <= pwdata[bit_autobaud_enable];
			end
			autobaud_rollover_flag <= ab_roll | (autobaud_rollover_flag
				& ~(wr_baud & ~pwdata[bit_autobaud_rollover_flag])); // RQ10
			if (wake_done) wakeup_enable <= 1'b0; // RQ14
			if (ab_done) autobaud_enable <= 1'b0; // RQ15
			if (wr && sel_mode) begin
				sync_mode <= pwdata[bit_sync_mode];
				clock_master <= pwdata[bit_clock_master];
				high_speed_select <= pwdata[bit_high_speed_select];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			divisor_low_byte <= reset_byte;
			divisor_high_byte <= reset_byte;
		end else if (ab_done) begin
			divisor_low_byte <= ab_value[7:0];
			if (wide_divisor_select) divisor_high_byte <= ab_value[15:8];
		end else begin
			if (wr && sel_lo) divisor_low_byte <= pwdata[7:0];
			if (wr && sel_hi) divisor_high_byte <= pwdata[7:0];
		end
	end

	// serial clock pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			serial_clock_out <= 1'b0;
		end else if (serial_clock_oe && state == st_data) begin
			serial_clock_out <= sync_clock_polarity ^ ph[1];
		end else begin
			serial_clock_out <= sync_clock_polarity; // RQ12
		end
	end
	assign serial_clock_oe = port_enable & master_mode; // RQ1 RQ18
	assign port_active = port_enable; // RQ1
	assign receive_data_ready = receive_full;

	// read back
	wire receive_idle_status = (state == st_idle) & ~ab_active; // RQ11
	wire [7:0] rsc_view = {port_enable, ninth_bit_receive_select, single_receive_enable,
		continuous_receive_enable, address_detect_enable, framing_error_flag,
		overrun_error_flag, received_ninth_bit};
	wire [7:0] baud_view = {autobaud_rollover_flag, receive_idle_status, 1'b0,
		sync_clock_polarity, wide_divisor_select, 1'b0, wakeup_enable, autobaud_enable};
	wire [7:0] mode_view = {5'h00, high_speed_select, clock_master, sync_mode};
	wire [7:0] read_byte = sel_rsc ? rsc_view
		: sel_baud ? baud_view
		: sel_lo ? divisor_low_byte
		: sel_hi ? divisor_high_byte
		: sel_data ? receive_data_register
		: sel_mode ? mode_view : 8'h00;
	assign prdata = {24'h000000, read_byte};
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
endmodule

// File: verif/uart_rx_checker_assertions.sv
`timescale 1ns/1ns
module uart_rx_checker (
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [uart_rx_baud_pkg::addr_width-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// pins
	input wire logic receive_pin,
	input wire logic serial_clock_in,
	input wire logic serial_clock_out,
	input wire logic serial_clock_oe,
	input wire logic port_active,
	// events
	input wire logic receive_data_ready,
	input wire logic wakeup_interrupt
);
	import uart_rx_baud_pkg::*;
	wire logic acc = psel && penable;
	wire logic mapped = (paddr[1:0] == 2'h0) && (paddr <= off_mode_config);
	wire logic rd_data = acc && !pwrite && paddr == off_receive_data_register;
	wire logic wr_status = acc && pwrite && paddr == off_receive_status_control;
	wire logic rd_status = acc && !pwrite && paddr == off_receive_status_control;
	wire logic wr_baud = acc && pwrite && paddr == off_baud_control;
	logic pol_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pol_q <= 1'b0;
		end else if (wr_baud) begin
			pol_q <= pwdata[bit_sync_clock_polarity];
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence wake_pulse;
		wakeup_interrupt ##1 !wakeup_interrupt;
	endsequence
	sequence clock_settled;
		!serial_clock_oe && !$past(serial_clock_oe) && pol_q == $past(pol_q);
	endsequence
	a_unmapped_refused: assert property (acc && !mapped |-> pslverr && (pwrite || prdata == 32'h0))
		else $error("unmapped access not refused");
	a_mapped_accepted: assert property (acc && mapped |-> pready && !pslverr)
		else $error("mapped access refused");
	a_read_upper_zero: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	a_port_enable_write: assert property (
		wr_status |=> port_active == $past(pwdata[bit_port_enable]))
		else $error("port enable not taken");
	a_status_port_bit: assert property (rd_status |-> prdata[bit_port_enable] == port_active)
		else $error("port enable readback differs");
	a_clock_oe_port: assert property (serial_clock_oe |-> port_active)
		else $error("clock driven with port off");
	a_clock_idle_level: assert property (clock_settled |-> serial_clock_out == pol_q)
		else $error("clock idle level wrong");
	a_ready_clears: assert property (rd_data |=> !receive_data_ready)
		else $error("ready not cleared by read");
	a_ready_stands: assert property (receive_data_ready && !rd_data |=> receive_data_ready)
		else $error("ready dropped without read");
	a_wakeup_pulse: assert property (wakeup_interrupt |-> wake_pulse)
		else $error("wake-up pulse too long");
	c_data_read: cover property (rd_data && receive_data_ready);
endmodule
bind uart_receive_and_baud_control uart_rx_checker chk_i (
	.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
	.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.receive_pin(receive_pin), .serial_clock_in(serial_clock_in),
	.serial_clock_out(serial_clock_out), .serial_clock_oe(serial_clock_oe),
	.port_active(port_active), .receive_data_ready(receive_data_ready),
	.wakeup_interrupt(wakeup_interrupt)
);

// File: verif/serial_node_model.sv
`timescale 1ns/1ns
module serial_node_model (
	// clock
	input wire logic pclk,
	// link
	input wire logic serial_clock_out,
	output logic receive_pin,
	output logic serial_clock_in
);
	int stall_cnt;
	initial receive_pin = 1'b1;
	initial serial_clock_in = 1'b0;
	task automatic wait_cycles(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// start low, lsb first, stop at given level, then idle mark
	task automatic send_async(input logic [8:0] data, input int nbits, input int bitc,
		input logic stop_level);
		int i;
		receive_pin <= 1'b0;
		wait_cycles(bitc);
		for (i = 0; i < nbits; i++) begin
			receive_pin <= data[i];
			wait_cycles(bitc);
		end
		receive_pin <= stop_level;
		wait_cycles(bitc);
		receive_pin <= 1'b1;
		wait_cycles(bitc);
	endtask
	// next bit after each clock fall to idle low; released line shows inverse
	task automatic send_sync(input logic [7:0] data);
		int i;
		int n;
		logic prev;
		receive_pin <= data[0];
		for (i = 1; i <= 8; i++) begin
			n = 0;
			prev = serial_clock_out;
			@(posedge pclk);
			while (!(prev === 1'b1 && serial_clock_out === 1'b0) && n < 200) begin
				prev = serial_clock_out;
				n++;
				@(posedge pclk);
			end
			if (n >= 200) stall_cnt++;
			receive_pin <= (i < 8) ? data[i] : ~data[7];
		end
	endtask
	// slave clock idles low; data set half a bit before each rising edge
	task automatic send_slave(input logic [7:0] data);
		int i;
		for (i = 0; i < 8; i++) begin
			receive_pin <= data[i];
			wait_cycles(4);
			serial_clock_in <= 1'b1;
			wait_cycles(4);
			serial_clock_in <= 1'b0;
		end
		wait_cycles(4);
		receive_pin <= 1'b1;
	endtask
	task automatic line_low(input int n);
		receive_pin <= 1'b0;
		wait_cycles(n);
		receive_pin <= 1'b1;
	endtask
endmodule

// File: verif/testbench.sv
`timescale 1ns/1ns
module testbench;
	import uart_rx_baud_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [addr_width-1:0] paddr;
	logic [31:0] pwdata, prdata, rdata;
	logic serial_clock_in, serial_clock_out, serial_clock_oe, port_active;
	logic receive_data_ready, wakeup_interrupt, receive_pin;
	int error_cnt, comparisons, wake_cnt, i;
	// rate table: async high-speed, 8-bit high byte ignored, 16-bit, fast
	logic [7:0] cfg_mode [4] = '{8'h04, 8'h00, 8'h00, 8'h04};
	logic [7:0] cfg_baud [4] = '{8'h00, 8'h00, 8'h08, 8'h08};
	logic [7:0] cfg_lo [4] = '{8'h01, 8'h00, 8'h01, 8'h03};
	logic [7:0] cfg_hi [4] = '{8'h00, 8'h01, 8'h00, 8'h00};
	int bitc [4] = '{32, 64, 32, 16};
	uart_receive_and_baud_control dut (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.receive_pin(receive_pin), .serial_clock_in(serial_clock_in),
		.serial_clock_out(serial_clock_out), .serial_clock_oe(serial_clock_oe),
		.port_active(port_active), .receive_data_ready(receive_data_ready),
		.wakeup_interrupt(wakeup_interrupt)
	);
	serial_node_model node (
		.pclk(pclk), .serial_clock_out(serial_clock_out), .receive_pin(receive_pin),
		.serial_clock_in(serial_clock_in)
	);
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		if (wakeup_interrupt === 1'b1) begin
			wake_cnt++;
		end
	end
	task automatic end_of_test();
		$display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
		int n;
		@(posedge pclk);
		paddr <= a;
		pwrite <= w;
		pwdata <= {24'h0, d};
		psel <= 1'b1;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			n++;
			if (n > 100) begin
				error_cnt++;
				end_of_test();
			end
			@(posedge pclk);
		end
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		xfer(a, 1'b1, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		xfer(a, 1'b0, 8'h00);
		chk(rdata, {24'h0, exp});
	endtask
	task automatic wait_rdy(input int max, input logic exp);
		int n;
		n = 0;
		while (receive_data_ready !== 1'b1 && n < max) begin
			@(posedge pclk);
			n++;
		end
		chk({31'h0, receive_data_ready}, {31'h0, exp});
	endtask
	task automatic set_rate(input int k);
		wr(off_mode_config, cfg_mode[k]);
		wr(off_baud_control, cfg_baud[k]);
		wr(off_divisor_high_byte, cfg_hi[k]);
		wr(off_divisor_low_byte, cfg_lo[k]);
	endtask
	initial begin
		{presetn, psel, penable, pwrite} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rd(off_receive_status_control, 8'h00);
		rd(off_baud_control, 8'h40);
		rd(off_divisor_low_byte, 8'h00);
		rd(off_divisor_high_byte, 8'h00);
		rd(off_mode_config, 8'h00);
		rd(8'h18, 8'h00);
		chk({31'h0, err}, 32'h1);
		wr(off_baud_control, 8'h98);
		rd(off_baud_control, 8'h58);
		wr(off_receive_status_control, 8'hff);
		rd(off_receive_status_control, 8'hf8);
		wr(off_receive_status_control, 8'h90);
		for (i = 0; i < 4; i++) begin
			set_rate(i);
			node.send_async({1'b0, 8'h3c ^ i[7:0]}, 8, bitc[i], 1'b1);
			wait_rdy(bitc[i] * 4, 1'b1);
			rd(off_receive_data_register, 8'h3c ^ i[7:0]);
			rd(off_receive_status_control, 8'h90);
		end
		set_rate(0);
		node.send_async(9'h05a, 8, 32, 1'b0);
		wait_rdy(128, 1'b1);
		rd(off_receive_status_control, 8'h94);
		rd(off_receive_data_register, 8'h5a);
		node.send_async(9'h011, 8, 32, 1'b1);
		wait_rdy(128, 1'b1);
		rd(off_receive_status_control, 8'h90);
		rd(off_receive_data_register, 8'h11);
		node.send_async(9'h021, 8, 32, 1'b1);
		node.send_async(9'h022, 8, 32, 1'b1);
		rd(off_receive_status_control, 8'h92);
		rd(off_receive_data_register, 8'h21);
		node.send_async(9'h023, 8, 32, 1'b1);
		wait_rdy(128, 1'b0);
		wr(off_receive_status_control, 8'h80);
		rd(off_receive_status_control, 8'h80);
		wr(off_receive_status_control, 8'hd8);
		node.send_async(9'h031, 9, 32, 1'b1);
		wait_rdy(128, 1'b0);
		node.send_async(9'h113, 9, 32, 1'b1);
		wait_rdy(128, 1'b1);
		rd(off_receive_status_control, 8'hd9);
		rd(off_receive_data_register, 8'h13);
		wr(off_receive_status_control, 8'h90);
		wr(off_baud_control, 8'h02);
		node.line_low(100);
		repeat (10) @(posedge pclk);
		chk(wake_cnt, 32'h1);
		rd(off_baud_control, 8'h40);
		wr(off_mode_config, 8'h00);
		wr(off_divisor_low_byte, 8'h07);
		wr(off_baud_control, 8'h01);
		node.send_async(9'h055, 8, 160, 1'b1);
		repeat (20) @(posedge pclk);
		rd(off_baud_control, 8'h40);
		rd(off_divisor_low_byte, 8'h01);
		xfer(off_receive_data_register, 1'b0, 8'h00);
		wr(off_receive_status_control, 8'h80);
		wr(off_mode_config, 8'h03);
		wr(off_baud_control, 8'h00);
		wr(off_divisor_low_byte, 8'h01);
		wr(off_receive_status_control, 8'ha0);
		node.send_sync(8'hc6);
		chk(node.stall_cnt, 32'h0);
		wait_rdy(64, 1'b1);
		chk({31'h0, serial_clock_oe}, 32'h1);
		rd(off_receive_data_register, 8'hc6);
		rd(off_receive_status_control, 8'h80);
		wr(off_mode_config, 8'h01);
		wr(off_receive_status_control, 8'h90);
		node.send_slave(8'h9b);
		wait_rdy(64, 1'b1);
		chk({31'h0, serial_clock_oe}, 32'h0);
		rd(off_receive_data_register, 8'h9b);
		wr(off_receive_status_control, 8'h80);
		wr(off_mode_config, 8'h00);
		wr(off_baud_control, 8'h10);
		repeat (3) @(posedge pclk);
		chk({31'h0, serial_clock_out}, 32'h1);
		end_of_test();
	end
endmodule
